// ---- core/jdb_pkg.sv ----
package jdb_pkg;

  // register byte addresses on the register port
  localparam logic [7:0] ADDR_JACK_CTRL = 8'hC7;
  localparam logic [7:0] ADDR_THR_A_D = 8'hC8;
  localparam logic [7:0] ADDR_THR_D_B = 8'hC9;
  localparam logic [7:0] ADDR_THR_B_C = 8'hCA;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // jack debounce and rate control, laid out exactly as the register bits 7..0
  typedef struct packed {
    logic [1:0] rem_deb;
    logic [1:0] detect_rate;
    logic [2:0] ins_deb;
    logic pause;
  } jdb_ctrl_s;

  localparam jdb_ctrl_s CTRL_RESET = '{rem_deb: 2'h0, detect_rate: 2'h3, ins_deb: 3'h2, pause: 1'b0};
  localparam logic [7:0] THR_A_D_RESET = 8'h0A;
  localparam logic [7:0] THR_D_B_RESET = 8'h16;
  localparam logic [7:0] THR_B_C_RESET = 8'h21;

  // sticky jack events, bit order 2..0
  typedef struct packed {
    logic complete;
    logic removed;
    logic inserted;
  } jdb_jack_ev_s;

  // sticky button events: press in bits 0..3, release in bits 4..7
  localparam int BIT_A_PRESS = 0;
  localparam int BIT_B_PRESS = 1;
  localparam int BIT_C_PRESS = 2;
  localparam int BIT_D_PRESS = 3;
  localparam int BIT_D_RELEASE = 4;
  localparam int BIT_C_RELEASE = 5;
  localparam int BIT_B_RELEASE = 6;
  localparam int BIT_A_RELEASE = 7;

  typedef enum logic [2:0] {BTN_NONE, BTN_A, BTN_B, BTN_C, BTN_D} jdb_button_e;
  typedef enum logic [2:0] {J_IDLE, J_INS_DEB, J_DETECT, J_PRESENT, J_REM_DEB} jdb_jack_state_e;

  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

  // times in ms, indexed by their field codes
  localparam logic [9:0] REM_DEB_MS [4] = '{10'd1, 10'd5, 10'd10, 10'd20};
  localparam logic [9:0] INS_DEB_MS [8] = '{10'd5, 10'd10, 10'd20, 10'd50, 10'd100, 10'd200, 10'd500, 10'd1000};
  localparam logic [9:0] BTN_INTERVAL_MS [8] = '{10'd0, 10'd2, 10'd5, 10'd10, 10'd50, 10'd100, 10'd200, 10'd500};

  // ramp: one step every (1 << rate) ms; 3-pole ends after 32 steps, 4-pole after 64
  localparam logic [9:0] RAMP_STEP_BASE_MS = 10'd1;
  localparam logic [6:0] RAMP_STEPS_3POLE = 7'd32;
  localparam logic [6:0] RAMP_STEPS_4POLE = 7'd64;

endpackage

// ---- core/jdb_ms_timer.sv ----
`timescale 1ns/1ps
// one-shot millisecond timer; a start while busy restarts it
module jdb_ms_timer #(
  parameter int unsigned CYCLES_PER_MS = jdb_pkg::CYCLES_PER_MS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [9:0] load_ms_in,
  output logic busy_out,
  output logic done_out
);
  localparam int CW = $clog2(CYCLES_PER_MS) + 1;
  localparam logic [CW-1:0] LAST_CYCLE = CW'(CYCLES_PER_MS - 1);

  logic [CW-1:0] cyc;
  logic [CW-1:0] next_cyc;
  logic [9:0] ms_left;
  logic [9:0] next_ms_left;
  logic next_busy;
  logic next_done;

  // a zero load is taken as 1 ms so the timer always ends
  always_comb
  begin
    next_cyc = cyc;
    next_ms_left = ms_left;
    next_busy = busy_out;
    next_done = 1'b0;
    if (start_in)
    begin
      next_cyc = '0;
      next_ms_left = (load_ms_in == 10'h000) ? 10'h001 : load_ms_in;
      next_busy = 1'b1;
    end
    else if (busy_out)
    begin
      if (cyc == LAST_CYCLE)
      begin
        next_cyc = '0;
        if (ms_left == 10'h001)
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
        else
          next_ms_left = ms_left - 10'h001;
      end
      else
        next_cyc = cyc + CW'(1);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cyc <= '0;
      ms_left <= 10'h000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      cyc <= next_cyc;
      ms_left <= next_ms_left;
      busy_out <= next_busy;
      done_out <= next_done;
    end
  end
endmodule

// ---- core/jdb_detector.sv ----
`timescale 1ns/1ps
// What this block does
// - removal debounce 1/5/10/20 ms, default 1 ms
// - insertion debounce 5 ms to 1 s, default 20 ms
// - 3-pole detect latency 32 to 256 ms
// - 4-pole detect latency 64 to 512 ms
// - latency set by sense-current ramp rate
// - pause bit stops periodic button measurements
// - paused still detects jack; disabled raises no jack event, only a held button's release
// - code below A-D threshold means button A
// - below D-B, not below A-D: button D
// - below B-C, not below D-B: button B
// - 4-pole measurement interval 2 to 500 ms
// - sticky press/release flags, write one clears
module jdb_detector #(
  parameter int unsigned CYCLES_PER_MS = jdb_pkg::CYCLES_PER_MS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic accdet_en_in,
  input wire logic [2:0] btn_interval_code_in,
  input wire logic jack_detect_in,
  input wire logic mic_present_in,
  input wire logic [7:0] meas_code_in,
  input wire logic meas_valid_in,
  input wire logic upper_is_button_c_in,
  input wire jdb_pkg::jdb_jack_ev_s jack_ev_clear_in,
  input wire logic [7:0] btn_ev_clear_in,
  output jdb_pkg::jdb_jack_ev_s jack_ev_out,
  output logic [7:0] btn_ev_out,
  output logic jack_present_out,
  output logic jack_4pole_out,
  output logic mic_sense_step_out,
  output logic [6:0] mic_sense_level_out,
  output logic meas_req_out,
  output jdb_pkg::jdb_button_e button_out
);
  // ascending threshold walk, anything above all three is left to the C/mic decision
  function automatic jdb_pkg::jdb_button_e classify(input logic [7:0] code, input logic [7:0] t_ad,
    input logic [7:0] t_db, input logic [7:0] t_bc, input logic is_c);
    if (code < t_ad)
      classify = jdb_pkg::BTN_A;
    else if (code < t_db)
      classify = jdb_pkg::BTN_D;
    else if (code < t_bc)
      classify = jdb_pkg::BTN_B;
    else
      classify = is_c ? jdb_pkg::BTN_C : jdb_pkg::BTN_NONE;
  endfunction

  // event bit for a button; release bits sit in the upper nibble
  function automatic logic [7:0] event_mask(input jdb_pkg::jdb_button_e b, input logic release_ev);
    logic [7:0] m;
    m = 8'h00;
    unique case (b)
      jdb_pkg::BTN_A: m[release_ev ? jdb_pkg::BIT_A_RELEASE : jdb_pkg::BIT_A_PRESS] = 1'b1;
      jdb_pkg::BTN_B: m[release_ev ? jdb_pkg::BIT_B_RELEASE : jdb_pkg::BIT_B_PRESS] = 1'b1;
      jdb_pkg::BTN_C: m[release_ev ? jdb_pkg::BIT_C_RELEASE : jdb_pkg::BIT_C_PRESS] = 1'b1;
      jdb_pkg::BTN_D: m[release_ev ? jdb_pkg::BIT_D_RELEASE : jdb_pkg::BIT_D_PRESS] = 1'b1;
      jdb_pkg::BTN_NONE: m = 8'h00;
      default: m = 8'h00;
    endcase
    event_mask = m;
  endfunction

  jdb_pkg::jdb_ctrl_s ctrl;
  jdb_pkg::jdb_ctrl_s next_ctrl;
  logic [7:0] thr_ad;
  logic [7:0] next_thr_ad;
  logic [7:0] thr_db;
  logic [7:0] next_thr_db;
  logic [7:0] thr_bc;
  logic [7:0] next_thr_bc;
  logic [7:0] next_rdata;

  jdb_pkg::jdb_jack_state_e jstate;
  jdb_pkg::jdb_jack_state_e next_jstate;
  logic [6:0] next_level;
  logic next_step;
  logic next_present;
  logic next_4pole;
  logic typed;
  logic next_typed;
  jdb_pkg::jdb_jack_ev_s jack_set;
  jdb_pkg::jdb_jack_ev_s next_jack_ev;
  logic jt_start;
  logic [9:0] jt_load;
  logic jt_done;

  logic bt_start;
  logic bt_busy;
  logic bt_done;
  logic btn_run;
  logic next_meas_req;
  jdb_pkg::jdb_button_e next_button;
  jdb_pkg::jdb_button_e seen;
  logic [7:0] btn_set;
  logic [7:0] next_btn_ev;

  // register port: writes land next edge, reads answer one edge later
  always_comb
  begin
    next_ctrl = ctrl;
    next_thr_ad = thr_ad;
    next_thr_db = thr_db;
    next_thr_bc = thr_bc;
    next_rdata = reg_rdata_out;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        jdb_pkg::ADDR_JACK_CTRL: next_ctrl = jdb_pkg::jdb_ctrl_s'(reg_wdata_in);
        jdb_pkg::ADDR_THR_A_D: next_thr_ad = reg_wdata_in;
        jdb_pkg::ADDR_THR_D_B: next_thr_db = reg_wdata_in;
        jdb_pkg::ADDR_THR_B_C: next_thr_bc = reg_wdata_in;
        default: next_ctrl = ctrl;
      endcase
    end
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        jdb_pkg::ADDR_JACK_CTRL: next_rdata = ctrl;
        jdb_pkg::ADDR_THR_A_D: next_rdata = thr_ad;
        jdb_pkg::ADDR_THR_D_B: next_rdata = thr_db;
        jdb_pkg::ADDR_THR_B_C: next_rdata = thr_bc;
        default: next_rdata = jdb_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctrl <= jdb_pkg::CTRL_RESET;
      thr_ad <= jdb_pkg::THR_A_D_RESET;
      thr_db <= jdb_pkg::THR_D_B_RESET;
      thr_bc <= jdb_pkg::THR_B_C_RESET;
      reg_rdata_out <= 8'h00;
    end
    else
    begin
      ctrl <= next_ctrl;
      thr_ad <= next_thr_ad;
      thr_db <= next_thr_db;
      thr_bc <= next_thr_bc;
      reg_rdata_out <= next_rdata;
    end
  end

  // one timer serves both debounces and the ramp steps, since they never overlap
  jdb_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_jack_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(jt_start),
    .load_ms_in(jt_load),
    .busy_out(),
    .done_out(jt_done)
  );

  // jack state machine; pause is not looked at here, so the jack keeps being watched
  always_comb
  begin
    next_jstate = jstate;
    next_level = mic_sense_level_out;
    next_step = 1'b0;
    next_present = jack_present_out;
    next_4pole = jack_4pole_out;
    next_typed = typed;
    jack_set = '0;
    jt_start = 1'b0;
    jt_load = jdb_pkg::RAMP_STEP_BASE_MS << ctrl.detect_rate;
    if (!accdet_en_in)
    begin
      next_jstate = jdb_pkg::J_IDLE;
      next_level = 7'h00;
      next_present = 1'b0;
      next_4pole = 1'b0;
      next_typed = 1'b0;
    end
    else
    begin
      unique case (jstate)
        jdb_pkg::J_IDLE:
          if (jack_detect_in)
          begin
            jt_start = 1'b1;
            jt_load = jdb_pkg::INS_DEB_MS[ctrl.ins_deb];
            next_jstate = jdb_pkg::J_INS_DEB;
          end
        jdb_pkg::J_INS_DEB:
          if (!jack_detect_in)
            next_jstate = jdb_pkg::J_IDLE;
          else if (jt_done)
          begin
            jack_set.inserted = 1'b1;
            next_present = 1'b1;
            next_level = 7'h00;
            jt_start = 1'b1;
            next_jstate = jdb_pkg::J_DETECT;
          end
        jdb_pkg::J_DETECT:
          if (!jack_detect_in)
          begin
            jt_start = 1'b1;
            jt_load = jdb_pkg::REM_DEB_MS[ctrl.rem_deb];
            next_jstate = jdb_pkg::J_REM_DEB;
          end
          else if (jt_done)
          begin
            // each step raises the sense current; the step period sets the latency
            next_step = 1'b1;
            next_level = mic_sense_level_out + 7'h01;
            if (next_level == jdb_pkg::RAMP_STEPS_3POLE && !mic_present_in)
            begin
              jack_set.complete = 1'b1;
              next_4pole = 1'b0;
              next_typed = 1'b1;
              next_jstate = jdb_pkg::J_PRESENT;
            end
            else if (next_level == jdb_pkg::RAMP_STEPS_4POLE)
            begin
              jack_set.complete = 1'b1;
              next_4pole = 1'b1;
              next_typed = 1'b1;
              next_jstate = jdb_pkg::J_PRESENT;
            end
            else
              jt_start = 1'b1;
          end
        jdb_pkg::J_PRESENT:
          if (!jack_detect_in)
          begin
            jt_start = 1'b1;
            jt_load = jdb_pkg::REM_DEB_MS[ctrl.rem_deb];
            next_jstate = jdb_pkg::J_REM_DEB;
          end
        jdb_pkg::J_REM_DEB:
          if (jack_detect_in)
          begin
            // a bounce during detection restarts the ramp from zero
            next_jstate = typed ? jdb_pkg::J_PRESENT : jdb_pkg::J_DETECT;
            next_level = typed ? mic_sense_level_out : 7'h00;
            jt_start = !typed;
          end
          else if (jt_done)
          begin
            jack_set.removed = 1'b1;
            next_present = 1'b0;
            next_4pole = 1'b0;
            next_typed = 1'b0;
            next_level = 7'h00;
            next_jstate = jdb_pkg::J_IDLE;
          end
      endcase
    end
    // set wins over a clear in the same cycle
    next_jack_ev = (jack_ev_out & ~jack_ev_clear_in) | jack_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      jstate <= jdb_pkg::J_IDLE;
      mic_sense_level_out <= 7'h00;
      mic_sense_step_out <= 1'b0;
      jack_present_out <= 1'b0;
      jack_4pole_out <= 1'b0;
      typed <= 1'b0;
      jack_ev_out <= '0;
    end
    else
    begin
      jstate <= next_jstate;
      mic_sense_level_out <= next_level;
      mic_sense_step_out <= next_step;
      jack_present_out <= next_present;
      jack_4pole_out <= next_4pole;
      typed <= next_typed;
      jack_ev_out <= next_jack_ev;
    end
  end

  // periodic measurement timer, only for a typed 4-pole jack while not paused
  assign btn_run = (jstate == jdb_pkg::J_PRESENT) && jack_4pole_out && !ctrl.pause
    && (btn_interval_code_in != 3'h0);
  assign bt_start = btn_run && !bt_busy;

  jdb_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_btn_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(bt_start),
    .load_ms_in(jdb_pkg::BTN_INTERVAL_MS[btn_interval_code_in]),
    .busy_out(bt_busy),
    .done_out(bt_done)
  );

  // classify each result; a change of button gives a release of the old and a press of the new
  always_comb
  begin
    next_meas_req = bt_done && btn_run;
    next_button = button_out;
    btn_set = 8'h00;
    seen = classify(meas_code_in, thr_ad, thr_db, thr_bc, upper_is_button_c_in);
    if (!jack_present_out || !jack_4pole_out)
      next_button = jdb_pkg::BTN_NONE;
    else if (meas_valid_in)
      next_button = seen;
    if (next_button != button_out)
      btn_set = event_mask(button_out, 1'b1) | event_mask(next_button, 1'b0);
    next_btn_ev = (btn_ev_out & ~btn_ev_clear_in) | btn_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meas_req_out <= 1'b0;
      button_out <= jdb_pkg::BTN_NONE;
      btn_ev_out <= 8'h00;
    end
    else
    begin
      meas_req_out <= next_meas_req;
      button_out <= next_button;
      btn_ev_out <= next_btn_ev;
    end
  end
endmodule

// ---- sim/jdb_detector_sva.sv ----
`timescale 1ns/1ps
// watches jack event timing, the sense-current ramp and the button sort at the ports
module jdb_detector_sva #(
  parameter int unsigned CYCLES_PER_MS = jdb_pkg::CYCLES_PER_MS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic accdet_en_in,
  input wire logic jack_detect_in,
  input wire logic [7:0] meas_code_in,
  input wire logic meas_valid_in,
  input wire logic [7:0] btn_ev_clear_in,
  input wire jdb_pkg::jdb_jack_ev_s jack_ev_out,
  input wire logic [7:0] btn_ev_out,
  input wire logic jack_present_out,
  input wire logic jack_4pole_out,
  input wire logic mic_sense_step_out,
  input wire logic [6:0] mic_sense_level_out,
  input wire logic meas_req_out,
  input wire jdb_pkg::jdb_button_e button_out
);
  jdb_pkg::jdb_ctrl_s ctrl, next_ctrl;
  logic [7:0] thr_ad, next_thr_ad, thr_db, next_thr_db;
  int hi, next_hi, lo, next_lo, gap, next_gap, ins_t, rem_t, step_t;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // register shadows and level counters; a disabled block restarts the high count
  always_comb
  begin
    next_ctrl = ctrl;
    next_thr_ad = thr_ad;
    next_thr_db = thr_db;
    if (reg_wr_in && reg_addr_in == jdb_pkg::ADDR_JACK_CTRL)
      next_ctrl = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == jdb_pkg::ADDR_THR_A_D)
      next_thr_ad = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == jdb_pkg::ADDR_THR_D_B)
      next_thr_db = reg_wdata_in;
    next_hi = (jack_detect_in && accdet_en_in) ? hi + 1 : 0;
    next_lo = jack_detect_in ? 0 : lo + 1;
    next_gap = (mic_sense_step_out || !jack_present_out) ? 0 : gap + 1;
  end

  always_ff @(posedge clk_in)
  begin
    ctrl <= rst_in ? jdb_pkg::CTRL_RESET : next_ctrl;
    thr_ad <= rst_in ? jdb_pkg::THR_A_D_RESET : next_thr_ad;
    thr_db <= rst_in ? jdb_pkg::THR_D_B_RESET : next_thr_db;
    hi <= rst_in ? 0 : next_hi;
    lo <= rst_in ? 0 : next_lo;
    gap <= rst_in ? 0 : next_gap;
  end

  // expected times in cycles for the current settings
  assign ins_t = int'(jdb_pkg::INS_DEB_MS[ctrl.ins_deb] * CYCLES_PER_MS);
  assign rem_t = int'(jdb_pkg::REM_DEB_MS[ctrl.rem_deb] * CYCLES_PER_MS);
  assign step_t = int'((32'd1 << ctrl.detect_rate) * CYCLES_PER_MS);

  property p_ins;
    $rose(jack_present_out) |-> hi >= ins_t && hi <= ins_t + 4;
  endproperty
  a_ins: assert property (p_ins) else $error("insert debounce off");
  property p_rem;
    $fell(jack_present_out) && accdet_en_in && $past(accdet_en_in) |-> lo >= rem_t && lo <= rem_t + 4;
  endproperty
  a_rem: assert property (p_rem) else $error("removal debounce off");
  property p_step;
    mic_sense_step_out |-> gap >= step_t - 4 && gap <= step_t + 4;
  endproperty
  a_step: assert property (p_step) else $error("ramp step spacing off");
  property p_level;
    $rose(jack_ev_out.complete) |-> (jack_4pole_out ? mic_sense_level_out == 7'd64 : mic_sense_level_out == 7'd32);
  endproperty
  a_level: assert property (p_level) else $error("ramp length off");
  property p_pause;
    ctrl.pause && $past(ctrl.pause) |-> !meas_req_out;
  endproperty
  a_pause: assert property (p_pause) else $error("request while paused");
  property p_btn_a;
    meas_valid_in && jack_present_out && jack_4pole_out && meas_code_in < thr_ad |=> button_out == jdb_pkg::BTN_A;
  endproperty
  a_btn_a: assert property (p_btn_a) else $error("code not sorted as A");
  property p_btn_d;
    meas_valid_in && jack_present_out && jack_4pole_out && meas_code_in >= thr_ad && meas_code_in < thr_db
      |=> button_out == jdb_pkg::BTN_D;
  endproperty
  a_btn_d: assert property (p_btn_d) else $error("code not sorted as D");
  property p_clr;
    btn_ev_clear_in[jdb_pkg::BIT_A_PRESS] && !meas_valid_in |=> !btn_ev_out[jdb_pkg::BIT_A_PRESS];
  endproperty
  a_clr: assert property (p_clr) else $error("press flag not cleared");
  property p_off;
    !accdet_en_in && !$past(accdet_en_in) |-> !jack_present_out && !$rose(jack_ev_out.inserted);
  endproperty
  a_off: assert property (p_off) else $error("jack seen while disabled");

  c_four: cover property ($rose(jack_ev_out.complete) && jack_4pole_out);
  c_btn_c: cover property (button_out == jdb_pkg::BTN_C);
  c_rem: cover property ($fell(jack_present_out));
endmodule

bind jdb_detector jdb_detector_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_sva (
  .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in), .accdet_en_in(accdet_en_in), .jack_detect_in(jack_detect_in),
  .meas_code_in(meas_code_in), .meas_valid_in(meas_valid_in), .btn_ev_clear_in(btn_ev_clear_in),
  .jack_ev_out(jack_ev_out), .btn_ev_out(btn_ev_out), .jack_present_out(jack_present_out),
  .jack_4pole_out(jack_4pole_out), .mic_sense_step_out(mic_sense_step_out),
  .mic_sense_level_out(mic_sense_level_out), .meas_req_out(meas_req_out), .button_out(button_out)
);

// ---- sim/jdb_headset.sv ----
`timescale 1ns/1ps
// headset jack on the far side: plug contact, mic leg and button impedance answers
module jdb_headset (
  input wire logic clk_in,
  input wire logic plugged_in,
  input wire logic four_pole_in,
  input wire logic [7:0] code_in,
  input wire logic meas_req_in,
  output logic jack_out,
  output logic mic_out,
  output logic [7:0] code_out = 8'h00,
  output logic valid_out = 1'b0
);
  // the mic leg is pulled down, so unplugged or 3-pole reads low
  assign jack_out = plugged_in;
  assign mic_out = plugged_in & four_pole_in;

  // one answer the cycle after a request; between answers the code lines toggle
  // so a stale value is never mistaken for a result
  always @(posedge clk_in)
  begin
    valid_out <= meas_req_in & plugged_in;
    code_out <= meas_req_in ? code_in : ~code_out; // code on the 256*Z/(Z+bias) scale
  end
endmodule

// ---- sim/jdb_detector_tb.sv ----
`timescale 1ns/1ps
module jdb_detector_tb;
  localparam int CPM = 10;
  localparam int LIMIT = 40000;
  localparam logic [7:0] CODES [8] = '{8'h09, 8'h0A, 8'h16, 8'h21, 8'h15, 8'h00, 8'h20, 8'hFF};
  localparam jdb_pkg::jdb_button_e WANTS [8] = '{jdb_pkg::BTN_A, jdb_pkg::BTN_D, jdb_pkg::BTN_B,
    jdb_pkg::BTN_C, jdb_pkg::BTN_D, jdb_pkg::BTN_A, jdb_pkg::BTN_B, jdb_pkg::BTN_NONE};
  localparam int PBIT [8] = '{0, 3, 1, 2, 3, 0, 1, 6};
  logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, en = 1'b1, is_c = 1'b0;
  logic plugged = 1'b0, pole4 = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, pcode = 8'h00, bclr = 8'h00;
  logic [2:0] ival = 3'h0;
  jdb_pkg::jdb_jack_ev_s jclr = '0;
  jdb_pkg::jdb_jack_ev_s jev;
  jdb_pkg::jdb_button_e btn;
  jdb_pkg::jdb_button_e want = jdb_pkg::BTN_NONE;
  logic [7:0] rdata, mcode, bev;
  logic jack, mic, mvalid, present, four, req;
  int n_fail = 0, samples_checked = 0, cyc = 0;

  jdb_detector #(.CYCLES_PER_MS(CPM)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .accdet_en_in(en), .btn_interval_code_in(ival),
    .jack_detect_in(jack), .mic_present_in(mic), .meas_code_in(mcode), .meas_valid_in(mvalid),
    .upper_is_button_c_in(is_c), .jack_ev_clear_in(jclr), .btn_ev_clear_in(bclr), .jack_ev_out(jev),
    .btn_ev_out(bev), .jack_present_out(present), .jack_4pole_out(four), .mic_sense_step_out(),
    .mic_sense_level_out(), .meas_req_out(req), .button_out(btn)
  );
  jdb_headset u_jack (
    .clk_in(clk_in), .plugged_in(plugged), .four_pole_in(pole4), .code_in(pcode), .meas_req_in(req),
    .jack_out(jack), .mic_out(mic), .code_out(mcode), .valid_out(mvalid)
  );

  always #5 clk_in = ~clk_in;

  // a hang counts as a mismatch and ends the run
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(what, rdata, exp);
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: return jev.inserted === 1'b1;
      1: return jev.complete === 1'b1;
      2: return jev.removed === 1'b1;
      default: return btn === want;
    endcase
  endfunction

  // bounded wait, n returns the cycles spent
  task wait_for(input int sel, input int lim, output int n);
    n = 0;
    while (!hit(sel) && n < lim)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask

  task clr_flags;
    @(posedge clk_in);
    jclr <= '1;
    bclr <= 8'hFF;
    @(posedge clk_in);
    jclr <= '0;
    bclr <= 8'h00;
  endtask

  task t_regs;
    rd_chk("ctrl_rst", jdb_pkg::ADDR_JACK_CTRL, jdb_pkg::CTRL_RESET);
    rd_chk("thr_ad_rst", jdb_pkg::ADDR_THR_A_D, 8'h0A);
    rd_chk("thr_db_rst", jdb_pkg::ADDR_THR_D_B, 8'h16);
    rd_chk("thr_bc_rst", jdb_pkg::ADDR_THR_B_C, 8'h21);
    wr_reg(jdb_pkg::ADDR_THR_B_C, 8'h5A);
    rd_chk("thr_bc_rw", jdb_pkg::ADDR_THR_B_C, 8'h5A);
    wr_reg(jdb_pkg::ADDR_THR_B_C, 8'h21);
    rd_chk("unmapped", 8'hCB, jdb_pkg::RDATA_UNMAPPED);
    $display("test registers done");
  endtask

  task t_jack(input logic [2:0] ins, input logic [1:0] rate, input logic p4, input logic pz);
    int n, d, steps;
    clr_flags();
    wr_reg(jdb_pkg::ADDR_JACK_CTRL, {2'h0, rate, ins, pz});
    @(posedge clk_in);
    pole4 <= p4;
    plugged <= 1'b1;
    d = int'(jdb_pkg::INS_DEB_MS[ins]) * CPM;
    wait_for(0, d + 20, n);
    chk("ins_time", n >= d && n <= d + 4, 1);
    steps = p4 ? 64 : 32;
    d = steps * (CPM << rate);
    wait_for(1, d + 4 * steps, n);
    chk("detect_time", n >= d - 4 && n <= d + 3 * steps, 1);
    chk("jack_kind", {present, four}, {1'b1, p4});
    $display("test jack insertion done");
  endtask

  task t_remove(input logic [1:0] rem);
    int n, d;
    clr_flags();
    wr_reg(jdb_pkg::ADDR_JACK_CTRL, {rem, 5'h00, 1'b1});
    @(posedge clk_in);
    plugged <= 1'b0;
    d = int'(jdb_pkg::REM_DEB_MS[rem]) * CPM;
    wait_for(2, d + 20, n);
    chk("rem_time", n >= d && n <= d + 4, 1);
    chk("jack_gone", {present, four}, 0);
    $display("test jack removal done");
  endtask

  task t_btn;
    int n;
    // interval code 0 must keep the periodic measurement silent
    n = 0;
    repeat (50)
    begin
      @(posedge clk_in);
      #1;
      n += req;
    end
    chk("req_code0", n, 0);
    @(posedge clk_in);
    ival <= 3'h1;
    for (int i = 0; i < 8; i++)
    begin
      clr_flags();
      @(posedge clk_in);
      pcode <= CODES[i];
      is_c <= (i == 3);
      want = WANTS[i];
      wait_for(3, 60, n);
      chk("button", btn, WANTS[i]);
      chk("event_bit", bev[PBIT[i]], 1);
    end
    clr_flags();
    #1;
    chk("cleared", bev, 0);
    $display("test buttons done");
  endtask

  task t_pause;
    int n;
    wr_reg(jdb_pkg::ADDR_JACK_CTRL, 8'h01);
    n = 0;
    repeat (100)
    begin
      @(posedge clk_in);
      #1;
      n += req;
    end
    chk("req_paused", n, 0);
    wr_reg(jdb_pkg::ADDR_THR_A_D, 8'h30);
    wr_reg(jdb_pkg::ADDR_JACK_CTRL, 8'h00);
    @(posedge clk_in);
    pcode <= 8'h2F;
    want = jdb_pkg::BTN_A;
    wait_for(3, 60, n);
    chk("button_new_thr", btn, jdb_pkg::BTN_A);
    $display("test pause done");
  endtask

  task t_off;
    clr_flags();
    @(posedge clk_in);
    en <= 1'b0;
    plugged <= 1'b1;
    repeat (300) @(posedge clk_in);
    #1;
    chk("no_events", {jev, present}, 0);
    @(posedge clk_in);
    plugged <= 1'b0;
    en <= 1'b1;
    $display("test disabled done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_jack(3'h2, 2'h0, 1'b0, 1'b0);
    t_remove(2'h0);
    t_jack(3'h0, 2'h3, 1'b1, 1'b0);
    t_btn();
    t_pause();
    t_remove(2'h3);
    t_jack(3'h7, 2'h1, 1'b1, 1'b1);
    t_off();
    report_and_stop();
  end
endmodule
